/* File: shared/sccr_defs.svh */
// register indices, field positions, reset values and timing counts
`ifndef SCCR_DEFS_SVH
`define SCCR_DEFS_SVH

// register indices; byte address is four times the index
`define SCCR_IDX_CTRL 8'h1c
`define SCCR_IDX_TRP 8'h1f

// control register fields
`define SCCR_BIT_UCLK 3
`define SCCR_BIT_DSUSP 4
`define SCCR_BIT_SCLK 6
`define SCCR_BIT_PS2 7
`define SCCR_DSUSP_MASK 8'h10
`define SCCR_CTRL_RST 8'h00

// table-read high pointer: address bits 10..8 in bits 2..0
`define SCCR_TRP_W 3
`define SCCR_TRP_LSB 8
`define SCCR_TRP_RST 3'h0

// timing
`define SCCR_CLK_PERIOD_NS 40
`define SCCR_WDT_SYS_DIV 4

`endif

/* File: shared/sccr_pkg.sv */
// types shared by the clock control block
package sccr_pkg;

	typedef logic [7:0] sccr_byte_t;

	// watchdog clock source chosen at build time
	typedef enum logic {
		SCCR_WDT_SYS4,
		SCCR_WDT_RC
	} sccr_wdt_src_t;

endpackage

/* File: hw/sccr_wdt_clk.sv */
// watchdog clock source selection and gating
`timescale 1ns/100ps
`default_nettype none
`include "sccr_defs.svh"

module sccr_wdt_clk #(
	parameter sccr_pkg::sccr_wdt_src_t SRC = sccr_pkg::SCCR_WDT_RC,
	parameter bit NORMAL_EN = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic halt_i,
	input wire logic rc_osc_i,
	output logic tick_o
);

	logic rc_s1;
	logic rc_s2;
	logic rc_s3;
	logic [1:0] div;
	wire rc_edge = rc_s2 & ~rc_s3;
	wire sys_edge = (div == 2'(`SCCR_WDT_SYS_DIV - 1));
	wire src_edge = (SRC == sccr_pkg::SCCR_WDT_RC) ? rc_edge : sys_edge;
	// outside halt the watchdog only counts when the build enables it
	wire run = NORMAL_EN | halt_i;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rc_s1 <= 1'b0;
			rc_s2 <= 1'b0;
			rc_s3 <= 1'b0;
			div <= 2'h0;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			rc_s1 <= rc_osc_i;
			rc_s2 <= rc_s1;
			rc_s3 <= rc_s2;
			div <= div + 2'h1;
			tick_o <= run & src_edge;
		end
	end

	property p_wdt_gate;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i && !NORMAL_EN && !halt_i |=> !tick_o;
	endproperty
	a_wdt_gate: assert property (p_wdt_gate)
		else $error("watchdog tick outside halt while disabled");

	property p_wdt_sys4;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		tick_o && SRC == sccr_pkg::SCCR_WDT_SYS4 |-> ##1 !tick_o [*3];
	endproperty
	a_wdt_sys4: assert property (p_wdt_sys4)
		else $error("system/4 watchdog tick came too soon");

endmodule
`default_nettype wire

/* File: hw/sccr_table_read_high_pointer.sv */
// table-read high pointer capture
`timescale 1ns/100ps
`default_nettype none
`include "sccr_defs.svh"

module sccr_trp #(
	parameter bit EN = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic tbl_read_i,
	input wire logic [10:0] tbl_addr_i,
	output logic [`SCCR_TRP_W-1:0] ptr_o
);

	genvar i;
	generate
		for (i = 0; i < `SCCR_TRP_W; i++) begin : g_bit
			always_ff @(posedge clk_sys_i) begin
				if (sys_rst_i) begin
					ptr_o[i] <= 1'b0;
				end else if (ce_i && tbl_read_i && EN) begin
					ptr_o[i] <= tbl_addr_i[`SCCR_TRP_LSB + i];
				end
			end
		end
	endgenerate

	property p_trp_cap;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ce_i && tbl_read_i && EN |=> ptr_o == $past(tbl_addr_i[10:8]);
	endproperty
	a_trp_cap: assert property (p_trp_cap)
		else $error("pointer does not hold address bits 10..8");

endmodule
`default_nettype wire

/* File: hw/sccr_top.sv */
// system clock control register block with classic wishbone slave
//
// Notes on behaviour
// - control bit 3 runs the usb clock when one and stops it when zero.
// - deep suspend before halt cuts power and disables low-voltage reset.
// - in usb mode the deep-suspend bit never becomes one.
// - control bit 6 picks 12 MHz when zero and 6 MHz when one.
// - control bit 7 is a firmware flag marking ps2 mode, reset to zero.
// - the pointer shows table-read address bits 10..8 in bits 2..0.
// - the pointer exists only when the build enables it.
// - the build picks the watchdog source: rc oscillator or system/4.
// - the build enables or disables the watchdog clock in normal mode.
// - usb mode is active while the usb select bit is one.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "sccr_defs.svh"

module sccr_top #(
	parameter int ADDR_W = 8,
	parameter bit TRP_EN = 1'b0,
	parameter sccr_pkg::sccr_wdt_src_t WDT_SRC = sccr_pkg::SCCR_WDT_RC,
	parameter bit WDT_NORMAL_EN = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic usb_mode_select_i,
	input wire logic halt_i,
	input wire logic tbl_read_i,
	input wire logic [10:0] tbl_addr_i,
	input wire logic rc_osc_i,
	output logic usb_clock_enable_o,
	output logic deep_suspend_power_cut_o,
	output logic system_clock_select_o,
	output logic ps2_mode_indicator_o,
	output logic low_voltage_reset_en_o,
	output logic power_reduced_o,
	output logic wdt_tick_o
);

	////////////////////////////////////////////////////////////////////////
	// build-time checks

	generate
		if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
			$error("sccr_top: ADDR_W must lie in 7..32");
		end
	endgenerate

	localparam logic [ADDR_W-1:0] CTRL_ADDR =
		ADDR_W'({`SCCR_IDX_CTRL, 2'b00});
	localparam logic [ADDR_W-1:0] TRP_ADDR =
		ADDR_W'({`SCCR_IDX_TRP, 2'b00});

	////////////////////////////////////////////////////////////////////////
	// state

	sccr_pkg::sccr_byte_t ctrl;
	logic [`SCCR_TRP_W-1:0] trp;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	wire bus_req = wb_cyc_i & wb_stb_i;
	wire hit_ctrl = (wb_adr_i == CTRL_ADDR);
	// with the option off the pointer is simply not mapped
	wire hit_trp = (wb_adr_i == TRP_ADDR) & TRP_EN;
	wire next_ack = bus_req & ~wb_ack_o;
	// the write lands on the edge that also sees the ack
	wire wr_ctrl = bus_req & wb_we_i & wb_ack_o & hit_ctrl & wb_sel_i[0];

	wire [31:0] rd_ctrl = {24'h00_0000, ctrl};
	wire [31:0] rd_trp = {29'h0000_0000, trp};
	wire [31:0] next_dat =
		hit_ctrl ? rd_ctrl :
		hit_trp ? rd_trp :
		32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// control register next value

	wire usb_mode = usb_mode_select_i;
	wire [7:0] wr_val = wb_dat_i[7:0];
	// bits 3, 6, 7 and the reserved bits take the written value as is
	wire [7:0] next_ctrl_raw = wr_ctrl ? wr_val : ctrl;
	// usb mode also knocks down a bit that was set before it began
	wire [7:0] ds_block = usb_mode ? `SCCR_DSUSP_MASK : 8'h00;
	wire [7:0] next_ctrl = next_ctrl_raw & ~ds_block;
	wire next_ds = next_ctrl[`SCCR_BIT_DSUSP];

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= next_ack;
			if (next_ack) begin
				wb_dat_o <= next_dat;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctrl <= `SCCR_CTRL_RST;
		end else if (ce_i) begin
			ctrl <= next_ctrl;
		end
	end

	// reset guard follows the bit in the same edge, no window with both on
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			low_voltage_reset_en_o <= 1'b1;
			power_reduced_o <= 1'b0;
		end else if (ce_i) begin
			low_voltage_reset_en_o <= ~next_ds;
			power_reduced_o <= next_ds & halt_i;
		end
	end

	assign usb_clock_enable_o = ctrl[`SCCR_BIT_UCLK];
	assign deep_suspend_power_cut_o = ctrl[`SCCR_BIT_DSUSP];
	assign system_clock_select_o = ctrl[`SCCR_BIT_SCLK];
	assign ps2_mode_indicator_o = ctrl[`SCCR_BIT_PS2];

	////////////////////////////////////////////////////////////////////////
	// build-time option blocks

	sccr_trp #(
		.EN(TRP_EN)
	) u_trp (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.tbl_read_i(tbl_read_i),
		.tbl_addr_i(tbl_addr_i),
		.ptr_o(trp)
	);

	sccr_wdt_clk #(
		.SRC(WDT_SRC),
		.NORMAL_EN(WDT_NORMAL_EN)
	) u_wdt (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.halt_i(halt_i),
		.rc_osc_i(rc_osc_i),
		.tick_o(wdt_tick_o)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_req;
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence s_wr_ctrl;
		ce_i && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
			hit_ctrl && wb_sel_i[0];
	endsequence

	sequence s_rd_trp;
		s_req ##0 (!wb_we_i && wb_adr_i == TRP_ADDR);
	endsequence

	property p_ack_next;
		s_req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("no ack one cycle after request");

	property p_ack_pulse;
		ce_i && wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");

	property p_uclk;
		s_wr_ctrl |=> usb_clock_enable_o == $past(wb_dat_i[3]);
	endproperty
	a_uclk: assert property (p_uclk)
		else $error("usb clock enable does not follow write");

	property p_ds_block;
		ce_i && usb_mode_select_i |=> !deep_suspend_power_cut_o;
	endproperty
	a_ds_block: assert property (p_ds_block)
		else $error("deep suspend set while in usb mode");

	property p_ds_write;
		s_wr_ctrl ##0 !usb_mode_select_i |=>
			deep_suspend_power_cut_o == $past(wb_dat_i[4]);
	endproperty
	a_ds_write: assert property (p_ds_write)
		else $error("deep suspend does not follow write");

	property p_lvr;
		deep_suspend_power_cut_o |-> !low_voltage_reset_en_o;
	endproperty
	a_lvr: assert property (p_lvr)
		else $error("low-voltage reset on during deep suspend");

	property p_pwr;
		ce_i && deep_suspend_power_cut_o && halt_i && !usb_mode_select_i
			&& !wr_ctrl |=> power_reduced_o;
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("power not reduced in halt with deep suspend");

	property p_sclk_hold;
		ce_i && !wr_ctrl |=> $stable(system_clock_select_o) &&
			$stable(ps2_mode_indicator_o);
	endproperty
	a_sclk_hold: assert property (p_sclk_hold)
		else $error("clock select or ps2_mode_indicator changed without write");

	property p_ps2_sclk;
		s_wr_ctrl |=> ps2_mode_indicator_o == $past(wb_dat_i[7]) &&
			system_clock_select_o == $past(wb_dat_i[6]);
	endproperty
	a_ps2_sclk: assert property (p_ps2_sclk)
		else $error("clock select or ps2_mode_indicator lost a write");

	property p_rsv;
		s_wr_ctrl |=> ctrl[2:0] == $past(wb_dat_i[2:0]) &&
			ctrl[5] == $past(wb_dat_i[5]);
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved bits do not store written value");

	property p_trp_rd;
		s_rd_trp |=> wb_dat_o == (TRP_EN ?
			{29'h0000_0000, $past(trp)} : 32'h0000_0000);
	endproperty
	a_trp_rd: assert property (p_trp_rd)
		else $error("pointer read returned wrong value");

endmodule
`default_nettype wire

/* File: testbench/sccr_top_tb.sv */
// self-checking bench for the clock control register block
`timescale 1ns/100ps
`default_nettype none

module sccr_top_tb;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, usb = 1'b0;
	logic halt = 1'b0, trd = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wd = 32'h0000_0000;
	logic [10:0] taddr = 11'h000;
	logic [31:0] rd;
	logic ack, ucken, dsusp, sclk, ps2, lv_en, pwr, tick;
	int fail_count = 0;
	int compares = 0;
	int ticks = 0;
	int t0;
	logic [31:0] expq[$];
	logic [7:0] v;

	always #20 clk_sys_i = ~clk_sys_i;

	// system/4 source so the tick rate is known without an rc stimulus
	sccr_top #(.ADDR_W(8), .TRP_EN(1'b1),
		.WDT_SRC(sccr_pkg::SCCR_WDT_SYS4), .WDT_NORMAL_EN(1'b0)) sccr_top_i (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.usb_mode_select_i(usb), .halt_i(halt), .tbl_read_i(trd),
		.tbl_addr_i(taddr), .rc_osc_i(1'b0), .usb_clock_enable_o(ucken),
		.deep_suspend_power_cut_o(dsusp), .system_clock_select_o(sclk),
		.ps2_mode_indicator_o(ps2), .low_voltage_reset_en_o(lv_en),
		.power_reduced_o(pwr), .wdt_tick_o(tick));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// one classic cycle; released only at the edge that samples ack
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_sys_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			fail_count++;
			$display("FAIL ack expected 1 seen %b", ack);
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	task automatic rdq(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
	endtask

	// bit outputs follow the stored control byte
	task automatic outs(input logic [7:0] c);
		chk("bit outputs", {26'h0, c[7], c[6], c[4], c[3], ~c[4], c[4] & halt},
			{26'h0, ps2, sclk, dsusp, ucken, lv_en, pwr});
	endtask

	////////////////////////////////////////////////////////////////////////
	// read results are judged here, oldest note first
	always @(posedge clk_sys_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (expq.size() > 0) begin
				chk("read data", expq.pop_front(), rd);
			end else begin
				chk("read count", 32'h0000_0000, 32'h0000_0001);
			end
		end
		if (tick === 1'b1) begin
			ticks <= ticks + 1;
		end
	end

	initial begin
		void'($urandom(32'h2813));
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rdq(8'h70, 32'h0000_0000);
		outs(8'h00);
		rdq(8'h7c, 32'h0000_0000);
		$display("test reset done");
		repeat (6) begin
			v = 8'($urandom) & 8'hef;
			wr(8'h70, {24'h0, v});
			rdq(8'h70, {24'h0, v});
			outs(v);
		end
		bus(1'b1, 8'h70, 32'h0000_00ff, 4'he);
		rdq(8'h70, {24'h0, v});
		$display("test control storage done");
		halt <= 1'b1;
		wr(8'h70, 32'h0000_0010);
		rdq(8'h70, 32'h0000_0010);
		outs(8'h10);
		usb <= 1'b1;
		wr(8'h70, 32'h0000_0098);
		rdq(8'h70, 32'h0000_0088);
		outs(8'h88);
		usb <= 1'b0;
		$display("test deep suspend done");
		wr(8'h40, 32'h0000_00ff);
		rdq(8'h40, 32'h0000_0000);
		rdq(8'h70, 32'h0000_0088);
		$display("test unmapped done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys_i);
			trd <= 1'b1;
			taddr <= {i[2:0], 8'($urandom)};
			@(posedge clk_sys_i);
			trd <= 1'b0;
			rdq(8'h7c, {29'h0, i[2:0]});
		end
		$display("test table pointer done");
		halt <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		t0 = ticks;
		repeat (40) @(posedge clk_sys_i);
		chk("halt ticks", 32'd10, 32'(ticks - t0));
		halt <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		t0 = ticks;
		repeat (40) @(posedge clk_sys_i);
		chk("normal ticks", 32'd0, 32'(ticks - t0));
		$display("test watchdog done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
